/* core/ucd_top.sv */
// Purpose: SMBus slave and run-time register bank with charger detect control
// Assumes: Front end and status inputs on clock_i; SMBus pins asynchronous
// Notes:   Command byte is the low address byte; page supplies the high byte
//
// Notes on behaviour
// RULE1: Run-time registers sit at 0x30E2 through 0x6103, reachable over SMBus.
// RULE2: Host sets the page register before touching any run-time register.
// RULE3: Detect register resets to 0x02; class field ignores writes. Register reads 0x00 after reset; code bits follow the decode.
// RULE4: Extended mode reports the full eight-code charger class set.
// RULE5: Without extended mode both port types report 001; 010 never appears. A class of 010 latched in extended mode stays until the next completion.
// RULE6: Done flag is read-only, set on completion, cleared on manual trigger.
// RULE7: Bits 2:1 give the allowed-current code 00 to 11.
// RULE8: Only conditions enabled in the detect mask feed the current code.
// RULE9: Writing 1 to bit 0 starts manual detection; reads 1 while running.
// RULE10: Trigger bit clears itself when the sequence finishes.
// RULE11: Writing 0 to the trigger does nothing; 0 reads as idle or finished.
// RULE12: Software never triggers manual detection while the hub operates.
// RULE13: Class, code, done and trigger all update in one cycle.
`timescale 1ns/1ps
module ucd_top
	import ucd_pkg::*;
(
	// System
	input  wire logic       clock_i,
	input  wire logic       reset_i,
	// SMBus pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// Detection front end
	input  wire logic       det_done_i,
	input  wire logic [2:0] det_class_i,
	output logic            det_start_o,
	output logic            det_ext_o,
	// Status sources
	input  wire logic       vbus_present_i,
	input  wire logic       configured_i,
	input  wire logic [7:0] custom_status_i,
	input  wire logic [7:0] port_power_status_i,
	input  wire logic [7:0] overcurrent_status_i
);
	localparam logic [7:0] UPDET_RST = `UCD_UPDET_RESET;

	ucd_top_t   r_reg;
	ucd_top_t   r_next;
	logic       scl_s;
	logic       sda_s;
	logic [2:0] dec_class;
	logic [1:0] dec_code;
	logic [2:0] cls_src;
	logic       sda_low;
	logic       rd_p;
	logic       wr_p;

	ucd_sync u_scl (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.d_i     (scl_i),
		.q_o     (scl_s)
	);

	ucd_sync u_sda (
		.clock_i (clock_i),
		.reset_i (reset_i),
		.d_i     (sda_i),
		.q_o     (sda_s)
	);

	// Class in the done cycle comes straight from the front end
	assign cls_src = det_done_i ? det_class_i : r_reg.cls;

	ucd_detect_decode u_dec (
		.raw_class_i (cls_src),
		.ext_i       (r_reg.ext),
		.mask_i      (r_reg.rw_regs[`UCD_IX_MASK]),
		.vbus_i      (vbus_present_i),
		.cfg_i       (configured_i),
		.class_o     (dec_class),
		.code_o      (dec_code)
	);

	function automatic logic [3:0] rw_index(input logic [15:0] a);
		case (a)
			`UCD_A_CUSTCTL:  rw_index = `UCD_IX_CUSTCTL;
			`UCD_A_MODE:     rw_index = `UCD_IX_MODE;
			`UCD_A_MASK:     rw_index = `UCD_IX_MASK;
			`UCD_A_PORTABLE: rw_index = `UCD_IX_PORTABLE;
			`UCD_A_PORT_SELECT_SUSPEND: rw_index = `UCD_IX_PORT_SELECT_SUSPEND;
			`UCD_A_CONNECT:  rw_index = `UCD_IX_CONNECT;
			`UCD_A_P0CTL1:   rw_index = `UCD_IX_P0CTL1;
			`UCD_A_P0CTL2:   rw_index = `UCD_IX_P0CTL2;
			`UCD_A_P0RUN:    rw_index = `UCD_IX_P0RUN;
			`UCD_A_P0DET:    rw_index = `UCD_IX_P0DET;
			default:         rw_index = `UCD_IX_NONE;
		endcase
	endfunction : rw_index

	always_comb begin
		logic       rise;
		logic       fall;
		logic [7:0] rd;
		logic [7:0] wd;
		logic [3:0] ix;
		rise   = 1'b0;
		fall   = 1'b0;
		rd     = `UCD_UNMAPPED;
		wd     = r_reg.sh;
		ix     = `UCD_IX_NONE;
		wr_p   = 1'b0;
		rd_p   = 1'b0;
		r_next = r_reg;
		rise   = scl_s && !r_reg.scl_q;
		fall   = !scl_s && r_reg.scl_q;
		r_next.scl_q = scl_s;
		r_next.sda_q = sda_s;
		r_next.start = 1'b0;
		r_next.ext   = r_reg.rw_regs[`UCD_IX_MODE][`UCD_MODE_EXT_BIT];

		// SMBus bit engine; SDA only moves while SCL is low
		if (scl_s && r_reg.scl_q && r_reg.sda_q && !sda_s) begin
			r_next.st     = smb_addr;
			r_next.cnt    = '0;
			r_next.sda_oe = 1'b0;
			r_next.idx    = '0;
		end else if (scl_s && r_reg.scl_q && !r_reg.sda_q && sda_s) begin
			r_next.st     = smb_idle;
			r_next.sda_oe = 1'b0;
		end else begin
			unique case (r_reg.st)
				smb_idle: begin
				end
				smb_addr, smb_wdata: begin
					if (rise) begin
						r_next.sh  = {r_reg.sh[6:0], sda_s};
						r_next.cnt = r_reg.cnt + 4'h1;
					end else if (fall && r_reg.cnt == `UCD_BIT_LAST) begin
						r_next.cnt = '0;
						if (r_reg.st == smb_wdata) begin
							r_next.sda_oe = 1'b1;
							r_next.st     = smb_wack;
							wr_p          = 1'b1;
						end else if (r_reg.sh[7:1] == `UCD_SMB_ADDR) begin
							r_next.rw     = r_reg.sh[0];
							r_next.sda_oe = 1'b1;
							r_next.st     = smb_addr_ack;
						end else begin
							r_next.st = smb_idle;
						end
					end
				end
				smb_addr_ack, smb_wack, smb_rack: begin
					if (r_reg.st == smb_rack && rise && sda_s) begin
						// Master NACK ends the read
						r_next.st = smb_idle;
					end else if (fall) begin
						if (r_reg.st == smb_wack || !r_reg.rw) begin
							r_next.sda_oe = 1'b0;
							r_next.st     = smb_wdata;
						end else begin
							r_next.sh     = r_reg.rd_data;
							r_next.sda_oe = ~r_reg.rd_data[7];
							r_next.cnt    = '0;
							r_next.st     = smb_rdata;
							rd_p          = 1'b1;
						end
					end
				end
				smb_rdata: begin
					if (fall) begin
						if (r_reg.cnt == `UCD_RBIT_LAST) begin
							r_next.sda_oe = 1'b0;
							r_next.st     = smb_rack;
						end else begin
							r_next.sh     = {r_reg.sh[6:0], 1'b0};
							r_next.sda_oe = ~r_reg.sh[6];
							r_next.cnt    = r_reg.cnt + 4'h1;
						end
					end
				end
				// Unused state code falls back to idle
				default: begin
					r_next.st     = smb_idle;
					r_next.sda_oe = 1'b0;
				end
			endcase
		end

		// Completion of manual or automatic detection
		if (det_done_i) begin
			r_next.cls  = dec_class; // RULE13
			r_next.done = 1'b1; // RULE6
			r_next.trig = 1'b0; // RULE10
		end
		r_next.code = dec_code; // RULE7

		// Framing: first byte is the command, the rest data
		if (wr_p) begin
			if (r_reg.idx == 2'h0) begin
				r_next.cmd = wd;
				r_next.idx = 2'h1;
				if (wd != `UCD_PAGE_CMD) begin
					r_next.ptr = {r_reg.page, wd}; // RULE2
				end
			end else if (r_reg.cmd == `UCD_PAGE_CMD) begin
				if (r_reg.idx == 2'h1) begin
					r_next.page = wd;
				end
				r_next.idx = 2'h2;
			end else begin
				r_next.ptr = r_reg.ptr + 16'h1;
				if (r_reg.ptr == `UCD_A_UPDET) begin
					// Class, done and code fields are not writable
					r_next.dbg = wd[`UCD_DBG_BIT]; // RULE3
					if (wd[`UCD_TRIG_BIT] && !r_reg.trig) begin
						r_next.trig  = 1'b1; // RULE9
						r_next.start = 1'b1;
						// Set wins when completion lands this cycle
						if (!det_done_i) begin
							r_next.done = 1'b0; // RULE6
						end
					end // RULE11
				end else begin
					ix = rw_index(r_reg.ptr); // RULE1
					if (ix != `UCD_IX_NONE) begin
						r_next.rw_regs[ix] = wd;
					end
				end
			end
		end else if (rd_p) begin
			r_next.ptr = r_reg.ptr + 16'h1;
		end

		// Read data prepared ahead of the next SCL fall
		case (r_reg.ptr)
			`UCD_A_UPDET: begin
				rd[`UCD_CLASS_MSB:`UCD_CLASS_LSB] = r_reg.cls;
				rd[`UCD_DONE_BIT]                 = r_reg.done;
				rd[`UCD_DBG_BIT]                  = r_reg.dbg;
				rd[`UCD_CODE_MSB:`UCD_CODE_LSB]   = r_reg.code;
				rd[`UCD_TRIG_BIT]                 = r_reg.trig; // RULE9
			end
			`UCD_A_CUSTSTAT: rd = custom_status_i & `UCD_STAT_MASK;
			`UCD_A_PWRSTAT:  rd = port_power_status_i;
			`UCD_A_OCSTAT:   rd = overcurrent_status_i;
			default: begin
				ix = rw_index(r_reg.ptr); // RULE1
				if (ix != `UCD_IX_NONE) begin
					rd = r_reg.rw_regs[ix];
				end
			end
		endcase
		r_next.rd_data = rd;
	end

	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			r_reg       <= '0;
			r_reg.scl_q <= 1'b1;
			r_reg.sda_q <= 1'b1;
			r_reg.page  <= `UCD_PAGE_RESET;
			r_reg.cls   <= UPDET_RST[`UCD_CLASS_MSB:`UCD_CLASS_LSB]; // RULE3
			r_reg.done  <= UPDET_RST[`UCD_DONE_BIT];
			r_reg.dbg   <= UPDET_RST[`UCD_DBG_BIT];
			r_reg.code  <= UPDET_RST[`UCD_CODE_MSB:`UCD_CODE_LSB];
			r_reg.trig  <= UPDET_RST[`UCD_TRIG_BIT];
		end else begin
			r_reg <= r_next;
		end
	end

	// Open drain: only ever pulls low
	assign sda_low     = 1'b0;
	assign sda_o       = sda_low;
	assign sda_oe_o    = r_reg.sda_oe;
	assign det_start_o = r_reg.start;
	assign det_ext_o   = r_reg.ext;
endmodule : ucd_top

/* shared/ucd_regs.svh */
// Purpose: Addresses, fields and codes of the run-time register bank
// Assumes: 16-bit internal byte space, 8-bit registers
// Notes:   Definitions only
`ifndef UCD_REGS_SVH
`define UCD_REGS_SVH

`define UCD_SMB_ADDR     7'h2d
`define UCD_PAGE_CMD     8'hff
`define UCD_PAGE_RESET   8'h30
`define UCD_UNMAPPED     8'h00
`define UCD_STAT_MASK    8'h0f

`define UCD_A_UPDET      16'h30e2
`define UCD_A_CUSTCTL    16'h30e3
`define UCD_A_CUSTSTAT   16'h30e4
`define UCD_A_PWRSTAT    16'h30e5
`define UCD_A_OCSTAT     16'h30e6
`define UCD_A_MODE       16'h30ec
`define UCD_A_MASK       16'h30ed
`define UCD_A_PORTABLE   16'h30ee
`define UCD_A_PORT_SELECT_SUSPEND   16'h318b
`define UCD_A_CONNECT    16'h318e
`define UCD_A_P0CTL1     16'h6100
`define UCD_A_P0CTL2     16'h6101
`define UCD_A_P0RUN      16'h6102
`define UCD_A_P0DET      16'h6103

`define UCD_RW_COUNT     10
`define UCD_IX_CUSTCTL   4'h0
`define UCD_IX_MODE      4'h1
`define UCD_IX_MASK      4'h2
`define UCD_IX_PORTABLE  4'h3
`define UCD_IX_PORT_SELECT_SUSPEND  4'h4
`define UCD_IX_CONNECT   4'h5
`define UCD_IX_P0CTL1    4'h6
`define UCD_IX_P0CTL2    4'h7
`define UCD_IX_P0RUN     4'h8
`define UCD_IX_P0DET     4'h9
`define UCD_IX_NONE      4'hf

`define UCD_UPDET_RESET  8'h02
`define UCD_CLASS_MSB    7
`define UCD_CLASS_LSB    5
`define UCD_DONE_BIT     4
`define UCD_DBG_BIT      3
`define UCD_CODE_MSB     2
`define UCD_CODE_LSB     1
`define UCD_TRIG_BIT     0

`define UCD_MODE_EXT_BIT 0
`define UCD_MSK_VBUS_BIT 0
`define UCD_MSK_CFG_BIT  1
`define UCD_MSK_CHG_BIT  2

`define UCD_CLS_DCP      3'h1
`define UCD_CLS_CDP      3'h2
`define UCD_CLS_LOW      3'h4
`define UCD_CLS_HIGH     3'h5
`define UCD_CLS_SUPER    3'h6

`define UCD_CUR_NONE     2'h0
`define UCD_CUR_100      2'h1
`define UCD_CUR_500      2'h2
`define UCD_CUR_1000     2'h3

`define UCD_BIT_LAST     4'h8
`define UCD_RBIT_LAST    4'h7
`endif

/* shared/ucd_pkg.sv */
// Purpose: Types of the charger-detect register bank
// Assumes: ucd_regs.svh on the include path
// Notes:   One packed state struct per module
package ucd_pkg;
`include "ucd_regs.svh"

	typedef enum logic [2:0] {
		smb_idle,
		smb_addr,
		smb_addr_ack,
		smb_wdata,
		smb_wack,
		smb_rdata,
		smb_rack
	} ucd_smb_state_t;

	typedef struct packed {
		logic s1;
		logic s2;
	} ucd_sync_t;

	typedef struct packed {
		ucd_smb_state_t                 st;
		logic [7:0]                     sh;
		logic [3:0]                     cnt;
		logic                           rw;
		logic                           scl_q;
		logic                           sda_q;
		logic                           sda_oe;
		logic [7:0]                     page;
		logic [7:0]                     cmd;
		logic [15:0]                    ptr;
		logic [1:0]                     idx;
		logic [`UCD_RW_COUNT-1:0][7:0]  rw_regs;
		logic [2:0]                     cls;
		logic                           done;
		logic                           dbg;
		logic [1:0]                     code;
		logic                           trig;
		logic                           start;
		logic                           ext;
		logic [7:0]                     rd_data;
	} ucd_top_t;
endpackage : ucd_pkg

/* core/ucd_sync.sv */
// Purpose: Two-flop synchroniser for one pin
// Assumes: Input asynchronous to clock_i
// Notes:   Only the second flop is visible
`timescale 1ns/1ps
module ucd_sync
	import ucd_pkg::*;
(
	// System
	input  wire logic clock_i,
	input  wire logic reset_i,
	// Data
	input  wire logic d_i,
	output logic      q_o
);
	ucd_sync_t s_reg;
	ucd_sync_t s_next;

	always_comb begin
		s_next.s1 = d_i;
		s_next.s2 = s_reg.s1;
	end

	// Idle bus level is high
	always_ff @(posedge clock_i) begin
		if (reset_i) begin
			s_reg <= '1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign q_o = s_reg.s2;
endmodule : ucd_sync

/* core/ucd_detect_decode.sv */
// Purpose: Charger class remap and allowed-current encoding
// Assumes: Raw class uses the extended encoding
// Notes:   Purely combinational
`timescale 1ns/1ps
module ucd_detect_decode
	import ucd_pkg::*;
(
	// Detection result
	input  wire logic [2:0] raw_class_i,
	input  wire logic       ext_i,
	// Conditions
	input  wire logic [7:0] mask_i,
	input  wire logic       vbus_i,
	input  wire logic       cfg_i,
	// Results
	output logic [2:0]      class_o,
	output logic [1:0]      code_o
);
	logic charger;

	always_comb begin
		class_o = raw_class_i;
		// Both port types fold into one code without extended mode
		if (!ext_i && raw_class_i == `UCD_CLS_CDP) begin
			class_o = `UCD_CLS_DCP; // RULE5
		end
		charger = (raw_class_i == `UCD_CLS_DCP) || (raw_class_i == `UCD_CLS_CDP) ||
			(raw_class_i == `UCD_CLS_LOW) || (raw_class_i == `UCD_CLS_HIGH) ||
			(raw_class_i == `UCD_CLS_SUPER); // RULE4
		if (mask_i[`UCD_MSK_CHG_BIT] && charger) begin
			code_o = `UCD_CUR_1000; // RULE7
		end else if (mask_i[`UCD_MSK_CFG_BIT] && cfg_i) begin
			code_o = `UCD_CUR_500; // RULE8
		end else if (mask_i[`UCD_MSK_VBUS_BIT] && vbus_i) begin
			code_o = `UCD_CUR_100;
		end else begin
			code_o = `UCD_CUR_NONE;
		end
	end
endmodule : ucd_detect_decode

/* verification/ucd_host_model.sv */
// Purpose: SMBus host for the register bank
// Assumes: SCL period 21 clocks, pull-ups on SCL and SDA
// Notes:   Page is set only when it differs
`timescale 1ns/1ps
module ucd_host_model
	import ucd_pkg::*;
(
	// System
	input  wire logic clock_i,
	// Bus
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_low_o
);
	logic [7:0] page_reg;
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		page_reg = 8'h00;
	end
	task automatic hold();
		repeat (10) @(posedge clock_i);
	endtask : hold
	task automatic start();
		@(posedge clock_i);
		sda_low_o <= 1'b0;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_low_o <= 1'b1;
		hold();
		scl_o <= 1'b0;
	endtask : start
	task automatic stop();
		@(posedge clock_i);
		sda_low_o <= 1'b1;
		hold();
		scl_o <= 1'b1;
		hold();
		sda_low_o <= 1'b0;
		hold();
	endtask : stop
	task automatic bit_io(input logic b, output logic r);
		@(posedge clock_i);
		sda_low_o <= !b;
		hold();
		scl_o <= 1'b1;
		hold();
		r = sda_i;
		scl_o <= 1'b0;
	endtask : bit_io
	task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
			q[i] = r;
		end
		bit_io(!mack, r);
		ack = !r;
	endtask : xfer
	// Page first, so the access lands in the right space
	task automatic cmd(input logic [15:0] a, output logic ok);
		logic [7:0] q;
		logic       k1;
		logic       k2;
		if (a[15:8] != page_reg) begin
			start();
			xfer({`UCD_SMB_ADDR, 1'b0}, 1'b0, q, k1);
			xfer(`UCD_PAGE_CMD, 1'b0, q, k1);
			xfer(a[15:8], 1'b0, q, k1);
			stop();
			page_reg = a[15:8];
		end
		start();
		xfer({`UCD_SMB_ADDR, 1'b0}, 1'b0, q, k1);
		xfer(a[7:0], 1'b0, q, k2);
		ok = k1 & k2;
	endtask : cmd
	task automatic wr(input logic [15:0] a, input logic [7:0] d, output logic ok);
		logic [7:0] q;
		logic       k;
		cmd(a, ok);
		xfer(d, 1'b0, q, k);
		stop();
		ok = ok & k;
	endtask : wr
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		logic k;
		cmd(a, k);
		start();
		xfer({`UCD_SMB_ADDR, 1'b1}, 1'b0, d, k);
		xfer(8'hff, 1'b0, d, k);
		stop();
	endtask : rd
endmodule : ucd_host_model

/* verification/ucd_top_asserts.sv */
// Purpose: Port-level checks of the register bank
// Assumes: SCL low phase of several clocks
// Notes:   Bound into ucd_top
`timescale 1ns/1ps
module ucd_top_asserts
	import ucd_pkg::*;
(
	input wire logic clock_i,
	input wire logic reset_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic det_done_i,
	input wire logic det_start_o,
	input wire logic det_ext_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (reset_i);
	logic busy_reg;
	logic act_reg;
	logic scl_reg;
	logic sda_reg;
	always_ff @(posedge clock_i) begin
		scl_reg <= scl_i;
		sda_reg <= sda_i;
		if (reset_i) begin
			busy_reg <= 1'b0;
			act_reg <= 1'b0;
		end else begin
			busy_reg <= det_start_o | (busy_reg & !det_done_i);
			if (scl_i && scl_reg && sda_reg && !sda_i) begin
				act_reg <= 1'b1;
			end else if (scl_i && scl_reg && !sda_reg && sda_i) begin
				act_reg <= 1'b0;
			end
		end
	end
	a_start_pulse: assert property (det_start_o |=> !det_start_o)
		else $error("start longer than one cycle");
	a_start_busy: assert property (det_start_o |-> !busy_reg)
		else $error("start while sequence running");
	a_start_scl_low: assert property (det_start_o |-> !scl_i)
		else $error("start outside a write");
	a_ext_scl_low: assert property ($changed(det_ext_o) |-> !scl_i)
		else $error("mode changed outside a write");
	a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
		else $error("SDA moved while SCL high");
	a_oe_hold: assert property ($rose(sda_oe_o) |=> sda_oe_o[*8])
		else $error("SDA low too short");
	a_sda_low_only: assert property (!sda_o)
		else $error("SDA driven high");
	a_oe_in_frame: assert property (sda_oe_o |-> act_reg)
		else $error("SDA driven outside a frame");
endmodule : ucd_top_asserts
bind ucd_top ucd_top_asserts u_ucd_top_asserts (.clock_i(clock_i), .reset_i(reset_i), .scl_i(scl_i),
	.sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .det_done_i(det_done_i),
	.det_start_o(det_start_o), .det_ext_o(det_ext_o));

/* verification/ucd_top_test.sv */
// Purpose: Self-checking bench of the register bank
// Assumes: Host model drives SMBus, bench drives the front end
// Notes:   Ends through test_done
`timescale 1ns/1ps
module ucd_top_test
	import ucd_pkg::*;
;
	logic clock_i = 1'b0, reset_i = 1'b1, scl, sda_low, sda_o, sda_oe_o, det_done_i = 1'b0;
	logic det_start_o, det_ext_o, vbus = 1'b0, cfg = 1'b0;
	logic [2:0] det_class_i = 3'h0;
	logic [7:0] cust = 8'hff, pwr = 8'h5c, ocs = 8'ha3;
	wire        sda = !(sda_low | sda_oe_o);
	int fail_count = 0, comparisons = 0, cycles = 0, starts = 0;
	localparam logic [15:0] RWA [10] = '{16'h30e3, 16'h30ec, 16'h30ed, 16'h30ee, 16'h318b,
		16'h318e, 16'h6100, 16'h6101, 16'h6102, 16'h6103};
	ucd_top u_ucd_top (.clock_i(clock_i), .reset_i(reset_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
		.sda_oe_o(sda_oe_o), .det_done_i(det_done_i), .det_class_i(det_class_i),
		.det_start_o(det_start_o), .det_ext_o(det_ext_o), .vbus_present_i(vbus), .configured_i(cfg),
		.custom_status_i(cust), .port_power_status_i(pwr), .overcurrent_status_i(ocs));
	ucd_host_model u_ucd_host_model (.clock_i(clock_i), .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low));
	always #4 clock_i = !clock_i;
	always @(posedge clock_i) begin
		cycles++;
		starts += (det_start_o === 1'b1);
		if (cycles == 90000) begin
			fail_count++;
			test_done();
		end
	end
	task automatic test_done();
		$display("comparisons %0d fail_count %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : test_done
	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			fail_count++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		logic k;
		u_ucd_host_model.wr(a, d, k);
		check("ack", {7'h0, k}, 8'h01);
	endtask : wr
	task automatic rd(input logic [15:0] a, input logic [7:0] exp);
		logic [7:0] q;
		u_ucd_host_model.rd(a, q);
		check("read", q, exp);
	endtask : rd
	task automatic pulse(input logic [2:0] c);
		@(posedge clock_i);
		det_done_i <= 1'b1;
		det_class_i <= c;
		@(posedge clock_i);
		det_done_i <= 1'b0;
	endtask : pulse
	task automatic t_rw();
		rd(16'h30e2, `UCD_UPDET_RESET & 8'hf9);
		for (int i = 0; i < 10; i++) begin
			rd(RWA[i], 8'h00);
			wr(RWA[i], 8'h30 + 8'(i));
			rd(RWA[i], 8'h30 + 8'(i));
		end
	endtask : t_rw
	task automatic t_ro();
		logic [7:0] q;
		logic       k;
		rd(16'h30e4, cust & 8'h0f);
		wr(16'h30e5, 8'h00);
		rd(16'h30e5, pwr);
		rd(16'h30e6, ocs);
		rd(16'h30e7, 8'h00);
		u_ucd_host_model.start();
		u_ucd_host_model.xfer({7'h2c, 1'b0}, 1'b0, q, k);
		u_ucd_host_model.stop();
		check("nack", {7'h0, k}, 8'h00);
	endtask : t_ro
	// Hub held idle here, so a manual run is allowed
	task automatic t_manual();
		wr(16'h30ec, 8'h01);
		check("ext", {7'h0, det_ext_o}, 8'h01);
		wr(16'h30ed, 8'h07);
		starts = 0;
		wr(16'h30e2, 8'h01);
		rd(16'h30e2, 8'h01);
		wr(16'h30e2, 8'h01);
		wr(16'h30e2, 8'h00);
		check("starts", 8'(starts), 8'h01);
		pulse(3'h2);
		rd(16'h30e2, 8'h56);
		wr(16'h30e2, 8'he8);
		rd(16'h30e2, 8'h5e);
		wr(16'h30e2, 8'h09);
		rd(16'h30e2, 8'h4f);
		check("starts", 8'(starts), 8'h02);
	endtask : t_manual
	task automatic t_classes();
		vbus <= 1'b1;
		cfg <= 1'b1;
		for (int e = 0; e < 2; e++) begin
			wr(16'h30ec, 8'(e));
			for (int c = 0; c < 8; c++) begin
				pulse(3'(c));
				rd(16'h30e2, {(c == 2 && e == 0) ? 3'h1 : 3'(c), 2'b11,
					(c inside {1, 2, 4, 5, 6}) ? 2'h3 : 2'h2, 1'b0});
			end
		end
	endtask : t_classes
	task automatic t_mask();
		logic [7:0] m [5] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h06};
		logic [1:0] x [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
		pulse(3'h1);
		for (int i = 0; i < 5; i++) begin
			wr(16'h30ed, m[i]);
			rd(16'h30e2, {3'h1, 2'b11, x[i], 1'b0});
		end
	endtask : t_mask
	initial begin
		repeat (6) @(posedge clock_i);
		reset_i <= 1'b0;
		repeat (3) @(posedge clock_i);
		t_rw();
		t_ro();
		t_manual();
		t_classes();
		t_mask();
		test_done();
	end
endmodule : ucd_top_test
